//--- hdl/clhr_top.sv
// clhr_top: home position logic and parameter staging for fully closed loop control.
// assumes: encoder events are one-cycle pulses synchronous to clk_i, dog is a clean level,
// ctrl_reset_i and power_on_i are single-cycle pulses from the amplifier's supervisor.
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module clhr_top
  import clhr_pkg::*;
#(
  parameter int POS_W = 32 // width of load-side position data
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ctrl_reset_i, // controller reset pulse
  input wire logic power_on_i, // power off-to-on pulse
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte enables
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic irq_o, // level interrupt
  input wire logic dog_i, // proximity dog level, high on dog
  input wire logic ref_mark_i, // linear scale reference mark pulse
  input wire logic zphase_i, // load-side rotary zero phase pulse
  input wire logic rev_mark_i, // motor revolution boundary pulse
  input wire logic [POS_W-1:0] load_pos_i, // load-side position data
  input wire logic [31:0] pos_cmd_i, // positioning command from controller
  input wire logic pos_cmd_vld_i, // positioning command strobe
  output logic [31:0] pos_cmd_o, // positioning command to servo loop
  output logic pos_cmd_vld_o, // positioning command strobe out
  output logic home_valid_o, // home position established
  output logic home_incomplete_o, // last home return failed
  output logic [POS_W-1:0] home_pos_o, // latched home position
  output logic [3:0] op_mode_o, // active operation_mode_select
  output logic [3:0] closed_loop_o, // active closed_loop_select
  output logic [3:0] err_detect_o, // active error_detect_select
  output logic [15:0] gear_num_a_o, // active feedback_gear_num_a
  output logic [15:0] gear_num_b_o, // active feedback_gear_num_b
  output logic [15:0] gear_den_a_o, // active feedback_gear_den_a
  output logic [15:0] gear_den_b_o, // active feedback_gear_den_b
  output logic [15:0] speed_dev_o, // speed_deviation_level
  output logic [15:0] pos_dev_o, // position_deviation_level
  output logic [15:0] filt_o // dual_feedback_filter
);

  // ====================================================================
  // state
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic irq;
    clhr_st_t st;
    logic dog_q;
    logic ref_seen;
    logic z_seen;
    logic [POS_W-1:0] ref_pos;
    logic [POS_W-1:0] home_pos;
    logic home_valid;
    logic incomplete;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] op_mode_s;
    logic [3:0] cl_sel_s;
    logic [3:0] hcond_s;
    logic [3:0] errdet_s;
    logic [15:0] gna_s;
    logic [15:0] gnb_s;
    logic [15:0] gda_s;
    logic [15:0] gdb_s;
    logic [15:0] spd_dev;
    logic [15:0] pos_dev;
    logic [15:0] filt;
    logic [3:0] op_mode_a;
    logic [3:0] cl_sel_a;
    logic [3:0] hcond_a;
    logic [3:0] errdet_a;
    logic [15:0] gna_a;
    logic [15:0] gnb_a;
    logic [15:0] gda_a;
    logic [15:0] gdb_a;
    logic [31:0] pos_cmd;
    logic pos_cmd_vld;
  } clhr_state_t;

  clhr_state_t s_reg;
  clhr_state_t s_next;

  // ====================================================================
  // helpers
  // byte-lane merge, used by every writable register except the interrupt status
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // zero-extend a 16-bit field onto the data bus
  function automatic logic [31:0] ext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : ext16

  // position captured as home for the active encoder kind
  function automatic logic [POS_W-1:0] home_of(input logic [1:0] enc, input logic [POS_W-1:0] pos,
                                               input logic [POS_W-1:0] refp);
    if (enc == CLHR_ENC_INC) begin
      return pos - refp;
    end
    return pos;
  endfunction : home_of

  // ====================================================================
  // next-state logic
  always_comb begin
    logic acc;
    logic wr;
    logic [31:0] m;
    logic start;
    logic dset;
    logic abort;
    logic dog_off;
    logic [1:0] enc;
    logic idx_ok;
    logic ref_ok;
    logic z_ok;
    logic set_done;
    logic set_fail;
    acc = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr = acc && wb_we_i;
    m = 32'h0000_0000;
    start = 1'b0;
    dset = 1'b0;
    abort = 1'b0;
    set_done = 1'b0;
    set_fail = 1'b0;
    enc = s_reg.cl_sel_a[1:0];
    dog_off = s_reg.dog_q && !dog_i;
    ref_ok = (enc != CLHR_ENC_INC) || s_reg.ref_seen || ref_mark_i;
    z_ok = s_reg.z_seen || zphase_i;
    // which index the dog return must have passed before dog off
    case (enc)
      CLHR_ENC_INC: idx_ok = s_reg.ref_seen || ref_mark_i;
      CLHR_ENC_ROT: idx_ok = z_ok;
      default: idx_ok = 1'b1;
    endcase
    s_next = s_reg;
    s_next.dog_q = dog_i;

    // wishbone slave: one wait state, ack drops the cycle after it was given
    s_next.ack = acc;
    s_next.rdata = 32'h0000_0000;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        CLHR_STAT_OFS: begin
          s_next.rdata = {26'h0, s_reg.st, s_reg.z_seen, s_reg.ref_seen,
                          s_reg.incomplete, s_reg.home_valid};
        end
        CLHR_IRQ_STAT_OFS: s_next.rdata = {30'h0, s_reg.irq_stat};
        CLHR_IRQ_MASK_OFS: s_next.rdata = {30'h0, s_reg.irq_mask};
        CLHR_HOME_POS_OFS: s_next.rdata = 32'(s_reg.home_pos);
        CLHR_OP_MODE_OFS: s_next.rdata = {28'h0, s_reg.op_mode_s};
        CLHR_CL_SEL_OFS: s_next.rdata = {28'h0, s_reg.cl_sel_s};
        CLHR_HCOND_OFS: s_next.rdata = {28'h0, s_reg.hcond_s};
        CLHR_ERRDET_OFS: s_next.rdata = {28'h0, s_reg.errdet_s};
        CLHR_GNA_OFS: s_next.rdata = ext16(s_reg.gna_s);
        CLHR_GNB_OFS: s_next.rdata = ext16(s_reg.gnb_s);
        CLHR_GDA_OFS: s_next.rdata = ext16(s_reg.gda_s);
        CLHR_GDB_OFS: s_next.rdata = ext16(s_reg.gdb_s);
        CLHR_SPD_DEV_OFS: s_next.rdata = ext16(s_reg.spd_dev);
        CLHR_POS_DEV_OFS: s_next.rdata = ext16(s_reg.pos_dev);
        CLHR_FILT_OFS: s_next.rdata = ext16(s_reg.filt);
        default: s_next.rdata = 32'h0000_0000; // control and unmapped read zero
      endcase
    end

    // register writes; staged values wait for their apply event
    if (wr) begin
      case (wb_adr_i)
        CLHR_CTRL_OFS: begin
          m = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
          start = m[CLHR_CTRL_START_BIT] && (s_reg.st == CLHR_IDLE); // busy: start is ignored
          dset = m[CLHR_CTRL_DSET_BIT];
          abort = m[CLHR_CTRL_ABORT_BIT];
        end
        CLHR_IRQ_MASK_OFS: begin
          m = merge({30'h0, s_reg.irq_mask}, wb_dat_i, wb_sel_i);
          s_next.irq_mask = m[1:0];
        end
        CLHR_OP_MODE_OFS: begin
          m = merge({28'h0, s_reg.op_mode_s}, wb_dat_i, wb_sel_i);
          s_next.op_mode_s = m[3:0];
        end
        CLHR_CL_SEL_OFS: begin
          m = merge({28'h0, s_reg.cl_sel_s}, wb_dat_i, wb_sel_i);
          s_next.cl_sel_s = m[3:0];
        end
        CLHR_HCOND_OFS: begin
          m = merge({28'h0, s_reg.hcond_s}, wb_dat_i, wb_sel_i);
          s_next.hcond_s = m[3:0];
        end
        CLHR_ERRDET_OFS: begin
          m = merge({28'h0, s_reg.errdet_s}, wb_dat_i, wb_sel_i);
          s_next.errdet_s = m[3:0];
        end
        CLHR_GNA_OFS: s_next.gna_s = 16'(merge(ext16(s_reg.gna_s), wb_dat_i, wb_sel_i));
        CLHR_GNB_OFS: s_next.gnb_s = 16'(merge(ext16(s_reg.gnb_s), wb_dat_i, wb_sel_i));
        CLHR_GDA_OFS: s_next.gda_s = 16'(merge(ext16(s_reg.gda_s), wb_dat_i, wb_sel_i));
        CLHR_GDB_OFS: s_next.gdb_s = 16'(merge(ext16(s_reg.gdb_s), wb_dat_i, wb_sel_i));
        // these act on the loop straight away, no apply event
        CLHR_SPD_DEV_OFS: s_next.spd_dev =
          16'(merge(ext16(s_reg.spd_dev), wb_dat_i, wb_sel_i));
        CLHR_POS_DEV_OFS: s_next.pos_dev =
          16'(merge(ext16(s_reg.pos_dev), wb_dat_i, wb_sel_i));
        CLHR_FILT_OFS: s_next.filt = 16'(merge(ext16(s_reg.filt), wb_dat_i, wb_sel_i));
        default: m = 32'h0000_0000;
      endcase
    end

    // apply staged parameters; a controller reset does not touch mode or gears
    if (power_on_i) begin
      s_next.op_mode_a = s_reg.op_mode_s;
      s_next.cl_sel_a = s_reg.cl_sel_s;
      s_next.gna_a = s_reg.gna_s;
      s_next.gnb_a = s_reg.gnb_s;
      s_next.gda_a = s_reg.gda_s;
      s_next.gdb_a = s_reg.gdb_s;
    end
    if (power_on_i || ctrl_reset_i) begin
      s_next.errdet_a = s_reg.errdet_s;
      s_next.hcond_a = s_reg.hcond_s;
    end

    // positioning commands are forwarded unchanged whatever the loop mode
    s_next.pos_cmd_vld = pos_cmd_vld_i;
    if (pos_cmd_vld_i) begin
      s_next.pos_cmd = pos_cmd_i;
    end

    // index tracking; a start clears the flags but an index in that cycle still counts
    if (start) begin
      s_next.ref_seen = 1'b0;
      s_next.z_seen = 1'b0;
    end
    if (ref_mark_i && (!s_reg.ref_seen || start)) begin
      s_next.ref_seen = 1'b1;
      s_next.ref_pos = load_pos_i;
    end
    if (zphase_i) begin
      s_next.z_seen = 1'b1;
    end

    // home return sequencer
    case (s_reg.st)
      CLHR_IDLE: begin
        if (start) begin
          s_next.st = CLHR_SEEK;
          s_next.home_valid = 1'b0;
          s_next.incomplete = 1'b0;
        end else if (dset) begin
          // data setting: zero phase, plus the reference mark on incremental scales, unless the condition select waives zero phase
          if (ref_ok && (z_ok || s_reg.hcond_a[CLHR_HCOND_NOZ_BIT])) begin
            s_next.home_pos = home_of(enc, load_pos_i, s_reg.ref_pos);
            s_next.home_valid = 1'b1;
            s_next.incomplete = 1'b0;
            set_done = 1'b1;
          end else begin
            s_next.home_valid = 1'b0;
            s_next.incomplete = 1'b1;
            set_fail = 1'b1;
          end
        end
      end
      CLHR_SEEK: begin
        if (abort) begin
          s_next.st = CLHR_IDLE;
          s_next.incomplete = 1'b1;
          set_fail = 1'b1;
        end else if (dog_off) begin
          if (idx_ok) begin
            s_next.st = CLHR_NEAR;
          end else begin
            s_next.st = CLHR_IDLE;
            s_next.incomplete = 1'b1;
            set_fail = 1'b1;
          end
        end
      end
      CLHR_NEAR: begin
        if (abort) begin
          s_next.st = CLHR_IDLE;
          s_next.incomplete = 1'b1;
          set_fail = 1'b1;
        end else if ((enc == CLHR_ENC_ROT) ? zphase_i : rev_mark_i) begin
          s_next.st = CLHR_IDLE;
          s_next.home_pos = home_of(enc, load_pos_i, s_reg.ref_pos);
          s_next.home_valid = 1'b1;
          set_done = 1'b1;
        end
      end
      default: s_next.st = CLHR_IDLE;
    endcase

    // sticky interrupt status, write one to clear, a new event wins over the clear
    if (wr && wb_adr_i == CLHR_IRQ_STAT_OFS && wb_sel_i[0]) begin
      s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[1:0];
    end
    if (set_done) begin
      s_next.irq_stat[CLHR_IRQ_DONE_BIT] = 1'b1;
    end
    if (set_fail) begin
      s_next.irq_stat[CLHR_IRQ_FAIL_BIT] = 1'b1;
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  // ====================================================================
  // state register; staged and active copies restart at defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= CLHR_IDLE;
      s_reg.gna_s <= CLHR_GEAR_RST;
      s_reg.gnb_s <= CLHR_GEAR_RST;
      s_reg.gda_s <= CLHR_GEAR_RST;
      s_reg.gdb_s <= CLHR_GEAR_RST;
      s_reg.gna_a <= CLHR_GEAR_RST;
      s_reg.gnb_a <= CLHR_GEAR_RST;
      s_reg.gda_a <= CLHR_GEAR_RST;
      s_reg.gdb_a <= CLHR_GEAR_RST;
      s_reg.spd_dev <= CLHR_SPD_DEV_RST;
      s_reg.pos_dev <= CLHR_POS_DEV_RST;
      s_reg.filt <= CLHR_FILT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ====================================================================
  // outputs, all straight from the state register
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign irq_o = s_reg.irq;
  assign pos_cmd_o = s_reg.pos_cmd;
  assign pos_cmd_vld_o = s_reg.pos_cmd_vld;
  assign home_valid_o = s_reg.home_valid;
  assign home_incomplete_o = s_reg.incomplete;
  assign home_pos_o = s_reg.home_pos;
  assign op_mode_o = s_reg.op_mode_a;
  assign closed_loop_o = s_reg.cl_sel_a;
  assign err_detect_o = s_reg.errdet_a;
  assign gear_num_a_o = s_reg.gna_a;
  assign gear_num_b_o = s_reg.gnb_a;
  assign gear_den_a_o = s_reg.gda_a;
  assign gear_den_b_o = s_reg.gdb_a;
  assign speed_dev_o = s_reg.spd_dev;
  assign pos_dev_o = s_reg.pos_dev;
  assign filt_o = s_reg.filt;

endmodule : clhr_top

`default_nettype wire

//--- hdl/clhr_pkg.sv
// clhr_pkg: constants, register map and types for the closed loop home return block.
// assumes: one 40 MHz clock, classic wishbone with 32-bit data, byte addressing.
// ====================================================================
// Summary of operation
// - absolute linear encoder: home counts whole motor turns from absolute zero
// - proximity dog return: home is nearest reference point after dog turns off
// - incremental linear: first reference mark after start is the home basis
// - absolute encoder zero may sit anywhere along the travel
// - serial rotary load encoder: dog home sits at load-side zero phase
// - data setting needs zero phase crossed first, plus the reference mark on incremental scales
// - home set condition select may waive the zero phase requirement
// - speed/position deviation levels and feedback filter act at once
// - mode and closed loop selection apply only at power on
// - feedback gear numerators and denominators apply only at power on
// - error detect select applies on controller reset or power on
// - home set condition select applies on controller reset or power on
// - positioning commands pass through exactly as in semi closed loop
// - incremental and rotary dog returns need the mark or zero phase seen before dog off; absolute needs neither
package clhr_pkg;

  // ====================================================================
  // register byte offsets
  localparam logic [7:0] CLHR_CTRL_OFS = 8'h00;
  localparam logic [7:0] CLHR_STAT_OFS = 8'h04;
  localparam logic [7:0] CLHR_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] CLHR_IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] CLHR_HOME_POS_OFS = 8'h10;
  localparam logic [7:0] CLHR_OP_MODE_OFS = 8'h14;
  localparam logic [7:0] CLHR_CL_SEL_OFS = 8'h18;
  localparam logic [7:0] CLHR_HCOND_OFS = 8'h1C;
  localparam logic [7:0] CLHR_ERRDET_OFS = 8'h20;
  localparam logic [7:0] CLHR_GNA_OFS = 8'h24;
  localparam logic [7:0] CLHR_GNB_OFS = 8'h28;
  localparam logic [7:0] CLHR_GDA_OFS = 8'h2C;
  localparam logic [7:0] CLHR_GDB_OFS = 8'h30;
  localparam logic [7:0] CLHR_SPD_DEV_OFS = 8'h34;
  localparam logic [7:0] CLHR_POS_DEV_OFS = 8'h38;
  localparam logic [7:0] CLHR_FILT_OFS = 8'h3C;

  // ====================================================================
  // field positions
  localparam int CLHR_CTRL_START_BIT = 0;
  localparam int CLHR_CTRL_DSET_BIT = 1;
  localparam int CLHR_CTRL_ABORT_BIT = 2;
  localparam int CLHR_IRQ_DONE_BIT = 0;
  localparam int CLHR_IRQ_FAIL_BIT = 1;
  localparam int CLHR_HCOND_NOZ_BIT = 0;

  // load-side encoder kinds, held in closed_loop_select[1:0]
  localparam logic [1:0] CLHR_ENC_ABS = 2'h0;
  localparam logic [1:0] CLHR_ENC_INC = 2'h1;
  localparam logic [1:0] CLHR_ENC_ROT = 2'h2;

  // ====================================================================
  // reset values
  localparam logic [15:0] CLHR_GEAR_RST = 16'h0001;
  localparam logic [15:0] CLHR_SPD_DEV_RST = 16'h0190;
  localparam logic [15:0] CLHR_POS_DEV_RST = 16'h0064;
  localparam logic [15:0] CLHR_FILT_RST = 16'h000A;

  // ====================================================================
  // home return sequencer, gray coded along idle -> seek -> near; near -> idle flips both bits
  typedef enum logic [1:0] {
    CLHR_IDLE = 2'b00,
    CLHR_SEEK = 2'b01,
    CLHR_NEAR = 2'b11
  } clhr_st_t;

endpackage : clhr_pkg

//--- tb/clhr_chk_sva.sv
// clhr_chk_sva: port-level assertions for clhr_top.
// assumes: bound to every clhr_top instance; a single clock domain.
`timescale 1ns/1ps
`default_nettype none

module clhr_chk_sva (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic ctrl_reset_i, // controller reset pulse
  input wire logic power_on_i, // power on pulse
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic zphase_i, // zero phase pulse
  input wire logic rev_mark_i, // revolution pulse
  input wire logic [31:0] pos_cmd_i, // command in
  input wire logic pos_cmd_vld_i, // command strobe in
  input wire logic [31:0] pos_cmd_o, // command out
  input wire logic pos_cmd_vld_o, // command strobe out
  input wire logic home_valid_o, // home set
  input wire logic home_incomplete_o, // home failed
  input wire logic [3:0] op_mode_o, // active mode
  input wire logic [3:0] err_detect_o, // active error detect
  input wire logic [15:0] gear_num_a_o, // active gear
  input wire logic [15:0] speed_dev_o // speed level
);
  // ====================================================================
  // one domain, so clock and reset are declared once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  cmd_pass_a: assert property (pos_cmd_vld_i |=> pos_cmd_vld_o && pos_cmd_o == $past(pos_cmd_i))
    else $error("positioning command altered or late");
  mode_hold_a: assert property (!rst_i && !power_on_i |=> $stable(op_mode_o))
    else $error("mode changed without power on");
  gear_hold_a: assert property (!rst_i && !power_on_i |=> $stable(gear_num_a_o))
    else $error("gear changed without power on");
  errdet_hold_a: assert property (!rst_i && !power_on_i && !ctrl_reset_i |=>
    $stable(err_detect_o)) else $error("error detect changed without apply event");
  speed_now_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == 8'h34 && wb_sel_i == 4'hF |=> speed_dev_o == $past(wb_dat_i[15:0]))
    else $error("speed level not applied at once");
  home_cause_a: assert property ($rose(home_valid_o) |-> $past(rev_mark_i) ||
    $past(zphase_i) || $past(wb_cyc_i && wb_we_i)) else $error("home set without cause");
  home_excl_a: assert property (!(home_valid_o && home_incomplete_o))
    else $error("home valid and incomplete together");

  home_set_c: cover property ($rose(home_valid_o));
  home_fail_c: cover property ($rose(home_incomplete_o));
  power_on_c: cover property (power_on_i);
endmodule : clhr_chk_sva

bind clhr_top clhr_chk_sva clhr_chk_sva_i (.clk_i, .rst_i, .ctrl_reset_i, .power_on_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .zphase_i, .rev_mark_i, .pos_cmd_i, .pos_cmd_vld_i, .pos_cmd_o, .pos_cmd_vld_o,
  .home_valid_o, .home_incomplete_o, .op_mode_o, .err_detect_o, .gear_num_a_o, .speed_dev_o);

`default_nettype wire

//--- tb/clhr_axis_model.sv
// clhr_axis_model: axis, encoders and controller on the block's far side.
// assumes: tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module clhr_axis_model (
  input wire logic clk_i, // system clock
  output logic dog_o, // proximity dog level
  output logic ref_o, // scale reference mark
  output logic z_o, // zero phase
  output logic rev_o, // motor revolution mark
  output logic [31:0] pos_o, // load position
  output logic [31:0] cmd_o, // positioning command
  output logic cmd_vld_o // command strobe
);
  // ====================================================================
  // idle axis: off dog, no marks
  initial begin
    {dog_o, ref_o, z_o, rev_o, cmd_vld_o} = 5'h0;
    pos_o = 32'h0;
    cmd_o = 32'h0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  // hold the axis still at one load position
  task automatic park(input logic [31:0] p);
    pos_o <= p;
    step(1);
  endtask : park

  // one sweep over the dog; a is the revolution point, b the zero phase point
  task automatic run(input bit with_ref, input logic [31:0] a, input logic [31:0] b);
    pos_o <= 32'h0000000A; // start from the far stroke end
    dog_o <= 1'b1;
    step(2);
    if (with_ref) begin // reference mark and zero phase ahead; without them an incremental or rotary return fails
      pos_o <= 32'h00000064;
      ref_o <= 1'b1;
      z_o <= 1'b1;
      step(1);
      {ref_o, z_o} <= 2'h0;
    end
    step(2);
    pos_o <= 32'h000000C8;
    dog_o <= 1'b0;
    step(3);
    pos_o <= a;
    rev_o <= 1'b1;
    step(1);
    rev_o <= 1'b0;
    step(2);
    pos_o <= b;
    z_o <= 1'b1;
    step(1);
    z_o <= 1'b0;
    step(2);
  endtask : run

  task automatic cmd(input logic [31:0] v); // issued as in semi closed loop
    cmd_o <= v;
    cmd_vld_o <= 1'b1;
    step(1);
    cmd_vld_o <= 1'b0;
    step(1);
  endtask : cmd
endmodule : clhr_axis_model

`default_nettype wire

//--- tb/tb_top.sv
// tb_top: self-checking bench for clhr_top.
// assumes: 40 MHz clock, wishbone master here, axis model on the far side.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import clhr_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ctrl_reset_i = 1'b0, power_on_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0, sel_v = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, load_pos_i, pos_cmd_i, pos_cmd_o, home_pos_o;
  logic dog_i, ref_mark_i, zphase_i, rev_mark_i, pos_cmd_vld_i, pos_cmd_vld_o;
  logic home_valid_o, home_incomplete_o;
  logic [3:0] op_mode_o, closed_loop_o, err_detect_o;
  logic [15:0] gear_num_a_o, gear_num_b_o, gear_den_a_o, gear_den_b_o;
  logic [15:0] speed_dev_o, pos_dev_o, filt_o;
  int num_errors = 0;
  int n_checks = 0;

  clhr_top clhr_top_i (.*);
  clhr_axis_model clhr_axis_model_i (.clk_i(clk_i), .dog_o(dog_i), .ref_o(ref_mark_i),
    .z_o(zphase_i), .rev_o(rev_mark_i), .pos_o(load_pos_i), .cmd_o(pos_cmd_i),
    .cmd_vld_o(pos_cmd_vld_i));

  always #12.5 clk_i = ~clk_i;

  // ====================================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; waits for ack, then idles a cycle before returning
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(32'(n), 32'h2);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask : wb

  task automatic pulse(input bit pw);
    if (pw) power_on_i <= 1'b1;
    else ctrl_reset_i <= 1'b1;
    @(posedge clk_i);
    {power_on_i, ctrl_reset_i} <= 2'h0;
    @(posedge clk_i);
  endtask : pulse

  function automatic logic [31:0] hs();
    return 32'({home_incomplete_o, home_valid_o});
  endfunction : hs

  // ====================================================================
  // scenarios
  task automatic t_params;
    chk({gear_num_a_o, gear_den_b_o}, 32'h00010001);
    chk({speed_dev_o, pos_dev_o}, 32'h01900064);
    chk(32'(filt_o), 32'hA);
    wb(1, CLHR_SPD_DEV_OFS, 32'h1234);
    wb(1, CLHR_POS_DEV_OFS, 32'h55);
    wb(1, CLHR_FILT_OFS, 32'h7);
    chk({speed_dev_o, pos_dev_o}, 32'h12340055);
    chk(32'(filt_o), 32'h7);
    wb(1, CLHR_OP_MODE_OFS, 32'h5);
    wb(1, CLHR_GNA_OFS, 32'h3);
    wb(1, CLHR_GDB_OFS, 32'h7);
    wb(1, CLHR_GNB_OFS, 32'h4);
    wb(1, CLHR_GDA_OFS, 32'h6);
    wb(1, CLHR_ERRDET_OFS, 32'h2);
    pulse(0);
    chk({op_mode_o, 12'h0, gear_num_a_o}, 32'h00000001);
    chk({gear_num_b_o, gear_den_a_o}, 32'h00010001);
    chk(32'(err_detect_o), 32'h2);
    pulse(1);
    chk({op_mode_o, 12'h0, gear_num_a_o}, 32'h50000003);
    chk(32'(gear_den_b_o), 32'h7);
    chk({gear_num_b_o, gear_den_a_o}, 32'h00040006);
    wb(0, CLHR_GNA_OFS, 32'h0);
    chk(rd, 32'h3);
    wb(0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("t_params done");
  endtask : t_params

  task automatic t_abs;
    wb(1, CLHR_IRQ_MASK_OFS, 32'h3);
    wb(1, CLHR_CTRL_OFS, 32'h1);
    clhr_axis_model_i.run(1, 32'h340, 32'h777);
    chk(home_pos_o, 32'h340);
    chk((hs() << 1) | 32'(irq_o), 32'h3);
    sel_v = 4'h0;
    wb(1, CLHR_IRQ_STAT_OFS, 32'h1);
    sel_v = 4'hF;
    chk(32'(irq_o), 32'h1);
    wb(1, CLHR_IRQ_STAT_OFS, 32'h1);
    chk(32'(irq_o), 32'h0);
    $display("t_abs done");
  endtask : t_abs

  task automatic t_inc;
    wb(1, CLHR_CL_SEL_OFS, 32'h1);
    pulse(0);
    chk(32'(closed_loop_o), 32'h0);
    pulse(1);
    chk(32'(closed_loop_o), 32'h1);
    wb(1, CLHR_IRQ_MASK_OFS, 32'h0);
    wb(1, CLHR_CTRL_OFS, 32'h1);
    clhr_axis_model_i.run(0, 32'h340, 32'h777);
    chk((hs() << 1) | 32'(irq_o), 32'h4);
    wb(0, CLHR_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h2);
    wb(1, CLHR_IRQ_STAT_OFS, 32'h2);
    wb(1, CLHR_CTRL_OFS, 32'h1);
    clhr_axis_model_i.run(1, 32'h340, 32'h777);
    chk(home_pos_o, 32'h2DC);
    chk(hs(), 32'h1);
    $display("t_inc done");
  endtask : t_inc

  task automatic t_rot;
    wb(1, CLHR_CL_SEL_OFS, 32'h2);
    pulse(1);
    wb(1, CLHR_CTRL_OFS, 32'h1);
    clhr_axis_model_i.run(1, 32'h340, 32'h777);
    chk(home_pos_o, 32'h777);
    wb(1, CLHR_CTRL_OFS, 32'h1);
    clhr_axis_model_i.run(0, 32'h340, 32'h777);
    chk(hs(), 32'h2);
    $display("t_rot done");
  endtask : t_rot

  // data set with no zero phase seen: refused until the waiver is applied
  task automatic t_dset;
    wb(1, CLHR_CTRL_OFS, 32'h1);
    wb(1, CLHR_CTRL_OFS, 32'h4);
    chk(hs(), 32'h2);
    clhr_axis_model_i.park(32'h9AB);
    wb(1, CLHR_CTRL_OFS, 32'h2);
    chk(hs(), 32'h2);
    wb(1, CLHR_HCOND_OFS, 32'h1);
    wb(1, CLHR_CTRL_OFS, 32'h2);
    chk(hs(), 32'h2);
    pulse(0);
    wb(1, CLHR_CTRL_OFS, 32'h2);
    chk(hs(), 32'h1);
    chk(home_pos_o, 32'h9AB);
    wb(0, CLHR_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    wb(0, CLHR_HOME_POS_OFS, 32'h0);
    chk(rd, 32'h9AB);
    clhr_axis_model_i.cmd(32'h1111);
    clhr_axis_model_i.cmd(32'h2222);
    chk(pos_cmd_o, 32'h2222);
    $display("t_dset done");
  endtask : t_dset

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ====================================================================
  // main sequence and a watchdog well past the fewer than 200 cycles needed
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_params;
    t_abs;
    t_inc;
    t_rot;
    t_dset;
    tally_and_finish;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    tally_and_finish;
  end
endmodule : tb_top

`default_nettype wire
